// [hw/pmic_regs_pkg.sv]
// register map, field positions, reset values and timing for the power control bank
package pmic_regs_pkg;

  // register addresses
  localparam logic [7:0] ADDR_INT_STATUS = 8'h02;
  localparam logic [7:0] ADDR_SYS_CTRL = 8'h07;
  localparam logic [7:0] ADDR_REG_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_OUT_STATUS = 8'h11;
  localparam logic [7:0] ADDR_VOLT_CHANGE = 8'h20;
  localparam logic [7:0] ADDR_B1_TGT_A = 8'h23;
  localparam logic [7:0] ADDR_B1_TGT_B = 8'h24;
  localparam logic [7:0] ADDR_B1_RAMP = 8'h25;
  localparam logic [7:0] ADDR_B2_TGT_A = 8'h29;
  localparam logic [7:0] ADDR_B2_TGT_B = 8'h2A;
  localparam logic [7:0] ADDR_B2_RAMP = 8'h2B;
  localparam logic [7:0] ADDR_BUCK_FUNC = 8'h38;
  localparam logic [7:0] ADDR_LIN1_VOLT = 8'h39;
  localparam logic [7:0] ADDR_LIN2_VOLT = 8'h3A;

  // field positions
  localparam int THERMAL_BIT = 1;
  localparam int DELAY_SEL_LSB = 4;
  localparam int B2_PWM_BIT = 2;
  localparam int B1_PWM_BIT = 1;
  localparam int EXT_CLK_BIT = 0;
  localparam int EN_LIN2_BIT = 6;
  localparam int EN_LIN1_BIT = 4;
  localparam int EN_B2_BIT = 2;
  localparam int EN_B1_BIT = 0;
  localparam int ST_BUCKS_BIT = 7;
  localparam int ST_LINS_BIT = 6;
  localparam int ST_LIN2_BIT = 5;
  localparam int ST_LIN1_BIT = 4;
  localparam int ST_B2_BIT = 2;
  localparam int ST_B1_BIT = 0;
  localparam int B2_SEL_BIT = 5;
  localparam int B2_GO_BIT = 4;
  localparam int B1_SEL_BIT = 1;
  localparam int B1_GO_BIT = 0;

  // reset values and fixed reserved patterns
  localparam logic [2:0] DELAY_SEL_RESET = 3'h2;
  localparam logic [7:0] SYS_CTRL_RSVD = 8'h08;
  localparam logic [7:0] ENABLE_RSVD = 8'h20;
  localparam logic [3:0] ENABLE_RESET = 4'hF;
  localparam logic [7:0] RAMP_RSVD = 8'h20;
  localparam logic [3:0] RAMP_RATE_RESET = 4'h8;
  localparam logic [4:0] TARGET_RESET = 5'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // timing: start-up delays counted in half-millisecond ticks
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SEQ_TICK_US = 500;
  localparam int SEQ_TICK_CYCLES = SEQ_TICK_US * 1000 * 1000 / CLK_PERIOD_PS;

  // per code, ticks for {linear two, linear one, buck two, buck one}
  localparam logic [19:0] DELAY_TABLE [0:7] = '{
    {5'h02, 5'h02, 5'h02, 5'h02},
    {5'h04, 5'h04, 5'h03, 5'h02},
    {5'h0C, 5'h06, 5'h04, 5'h03},
    {5'h02, 5'h02, 5'h04, 5'h03},
    {5'h0C, 5'h06, 5'h04, 5'h03},
    {5'h04, 5'h04, 5'h03, 5'h03},
    {5'h03, 5'h02, 5'h04, 5'h06},
    {5'h16, 5'h0C, 5'h06, 5'h04}
  };

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_REG = 3'b010,
    I2C_WRITE = 3'b011,
    I2C_READ = 3'b100
  } i2c_state_e;

endpackage : pmic_regs_pkg

// [hw/pmic_control_register_bank.sv]
// serial slave, control registers and start-up sequencer of the power unit
//
// Contract
// - thermal bit follows over-temperature, resets zero
// - three-bit start-up delay selector, read/write
// - regulators start at table delays after enable
// - delay selector resets to factory code 010
// - force-pwm bits per buck, factory defaults
// - four enable bits, reset to one
// - valid flags plus both-bucks and both-linears
// - target select bits pick first/second target
// - ramp-go bits hold or move to target
// - buck one targets and ramp decoded
// - buck two targets and ramp decoded
// - linear regulator voltage registers decoded
// - buck function rw; status registers read-only
// - fixed seven-bit slave address by mask option
`timescale 1ns/1ps
`default_nettype none
module pmic_control_register_bank
  import pmic_regs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A, // arbitrary value, set per mask option
  parameter int TICK_CYCLES = SEQ_TICK_CYCLES,
  parameter logic [2:0] DELAY_SEL_DEFAULT = DELAY_SEL_RESET,
  parameter logic B1_PWM_DEFAULT = 1'b0,
  parameter logic B2_PWM_DEFAULT = 1'b0,
  parameter logic [4:0] B1_TARGET_DEFAULT = TARGET_RESET,
  parameter logic [4:0] B2_TARGET_DEFAULT = TARGET_RESET
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // serial port
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // analog monitors
  input wire logic die_over_temp,
  input wire logic master_enable,
  input wire logic buck_one_good,
  input wire logic buck_two_good,
  input wire logic linear_one_good,
  input wire logic linear_two_good,
  // regulator start controls
  output logic buck_one_on,
  output logic buck_two_on,
  output logic linear_one_on,
  output logic linear_two_on,
  // mode and voltage controls
  output logic buck_one_force_pwm,
  output logic buck_two_force_pwm,
  output logic external_clock_select,
  output logic [4:0] buck_one_vout_code,
  output logic [4:0] buck_two_vout_code,
  output logic [3:0] buck_one_ramp_rate,
  output logic [3:0] buck_two_ramp_rate,
  output logic [7:0] buck_function,
  output logic [7:0] linear_reg_one_voltage,
  output logic [7:0] linear_reg_two_voltage
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // register fields
  logic thermal_flag;
  logic [2:0] power_on_delay_select;
  logic ext_clk_bit;
  logic b1_pwm_bit;
  logic b2_pwm_bit;
  logic [3:0] enable_bits;
  logic [5:0] valid_flags;
  logic b1_sel;
  logic b1_go;
  logic b2_sel;
  logic b2_go;
  logic [4:0] b1_tgt_a;
  logic [4:0] b1_tgt_b;
  logic [4:0] b2_tgt_a;
  logic [4:0] b2_tgt_b;
  logic [3:0] b1_rate;
  logic [3:0] b2_rate;
  logic [7:0] func_reg;
  logic [7:0] lin1_reg;
  logic [7:0] lin2_reg;

  // serial engine state
  i2c_state_e state;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] tx_byte;
  logic [7:0] reg_ptr;
  logic reading;
  logic master_nack;
  logic drive_low;
  logic wr_pulse;
  logic [7:0] wr_ptr;
  logic [7:0] wr_data;

  // sequencer state
  logic [TICK_W-1:0] tick_cnt;
  logic [4:0] seq_ticks;

  // pin edge and condition decode
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_cond = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_cond = scl_in & scl_q & ~sda_q & sda_in;
  wire addr_match = (shift_in[7:1] == SLAVE_ADDR);

  // assembled read values
  wire [7:0] rd_int = {6'h00, thermal_flag, 1'b0};
  wire [7:0] rd_sys = SYS_CTRL_RSVD | {1'b0, power_on_delay_select, 1'b0, b2_pwm_bit,
                                       b1_pwm_bit, ext_clk_bit};
  wire [7:0] rd_en = ENABLE_RSVD | {1'b0, enable_bits[3], 1'b0, enable_bits[2], 1'b0,
                                    enable_bits[1], 1'b0, enable_bits[0]};
  wire [7:0] rd_stat = {valid_flags[5:2], 1'b0, valid_flags[1], 1'b0, valid_flags[0]};
  wire [7:0] rd_vcc = {2'h0, b2_sel, b2_go, 2'h0, b1_sel, b1_go};

  // read decode; unmapped addresses answer zero
  wire [7:0] rd_data =
    (reg_ptr == ADDR_INT_STATUS) ? rd_int :
    (reg_ptr == ADDR_SYS_CTRL) ? rd_sys :
    (reg_ptr == ADDR_REG_ENABLE) ? rd_en :
    (reg_ptr == ADDR_OUT_STATUS) ? rd_stat :
    (reg_ptr == ADDR_VOLT_CHANGE) ? rd_vcc :
    (reg_ptr == ADDR_B1_TGT_A) ? {3'h0, b1_tgt_a} :
    (reg_ptr == ADDR_B1_TGT_B) ? {3'h0, b1_tgt_b} :
    (reg_ptr == ADDR_B1_RAMP) ? (RAMP_RSVD | {4'h0, b1_rate}) :
    (reg_ptr == ADDR_B2_TGT_A) ? {3'h0, b2_tgt_a} :
    (reg_ptr == ADDR_B2_TGT_B) ? {3'h0, b2_tgt_b} :
    (reg_ptr == ADDR_B2_RAMP) ? (RAMP_RSVD | {4'h0, b2_rate}) :
    (reg_ptr == ADDR_BUCK_FUNC) ? func_reg :
    (reg_ptr == ADDR_LIN1_VOLT) ? lin1_reg :
    (reg_ptr == ADDR_LIN2_VOLT) ? lin2_reg : 8'h00;

  // write decode; status registers have no strobe at all
  wire wr_sys = wr_pulse && (wr_ptr == ADDR_SYS_CTRL);
  wire wr_en = wr_pulse && (wr_ptr == ADDR_REG_ENABLE);
  wire wr_vcc = wr_pulse && (wr_ptr == ADDR_VOLT_CHANGE);
  wire wr_b1a = wr_pulse && (wr_ptr == ADDR_B1_TGT_A);
  wire wr_b1b = wr_pulse && (wr_ptr == ADDR_B1_TGT_B);
  wire wr_b1r = wr_pulse && (wr_ptr == ADDR_B1_RAMP);
  wire wr_b2a = wr_pulse && (wr_ptr == ADDR_B2_TGT_A);
  wire wr_b2b = wr_pulse && (wr_ptr == ADDR_B2_TGT_B);
  wire wr_b2r = wr_pulse && (wr_ptr == ADDR_B2_RAMP);
  wire wr_func = wr_pulse && (wr_ptr == ADDR_BUCK_FUNC);
  wire wr_lin1 = wr_pulse && (wr_ptr == ADDR_LIN1_VOLT);
  wire wr_lin2 = wr_pulse && (wr_ptr == ADDR_LIN2_VOLT);

  // sequencer decode
  wire [19:0] delay_row = DELAY_TABLE[power_on_delay_select];
  wire tick_done = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
  wire b1_due = seq_ticks >= delay_row[4:0];
  wire b2_due = seq_ticks >= delay_row[9:5];
  wire l1_due = seq_ticks >= delay_row[14:10];
  wire l2_due = seq_ticks >= delay_row[19:15];

  // open-drain pad: only ever pulls low
  assign sda_out = 1'b0;

  // pin samples for edge detection, plus the registered sda_oe_n pad enable
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      sda_oe_n <= ~drive_low;
    end
  end

  // serial byte engine: bits taken on scl rise, sda changed on scl fall
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= I2C_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      tx_byte <= 8'h00;
      reg_ptr <= 8'h00;
      reading <= 1'b0;
      master_nack <= 1'b0;
      drive_low <= 1'b0;
      wr_pulse <= 1'b0;
      wr_ptr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_pulse <= 1'b0;
      if (start_cond) begin // repeated start behaves like a first start
        state <= I2C_ADDR;
        bit_cnt <= 4'h0;
        drive_low <= 1'b0;
      end else if (stop_cond) begin
        state <= I2C_IDLE;
        bit_cnt <= 4'h0;
        drive_low <= 1'b0;
      end else if (state != I2C_IDLE) begin
        if (scl_rise) begin
          if (bit_cnt < 4'h8) begin
            shift_in <= {shift_in[6:0], sda_in};
          end
          if (bit_cnt == 4'h8) begin
            master_nack <= sda_in;
          end
          if (bit_cnt < 4'h9) begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        if (scl_fall) begin
          case (bit_cnt)
            4'h8: begin
              if (state == I2C_READ) begin
                drive_low <= 1'b0;
                reg_ptr <= reg_ptr + 8'h01;
              end else if (state == I2C_ADDR && !addr_match) begin
                state <= I2C_IDLE;
                bit_cnt <= 4'h0;
              end else begin
                drive_low <= 1'b1;
                if (state == I2C_ADDR) begin
                  reading <= shift_in[0];
                end
                if (state == I2C_REG) begin
                  reg_ptr <= shift_in;
                end
                if (state == I2C_WRITE) begin
                  wr_pulse <= 1'b1;
                  wr_ptr <= reg_ptr;
                  wr_data <= shift_in;
                  reg_ptr <= reg_ptr + 8'h01;
                end
              end
            end
            4'h9: begin
              bit_cnt <= 4'h0;
              drive_low <= 1'b0;
              case (state)
                I2C_ADDR: begin
                  if (reading) begin
                    state <= I2C_READ;
                    tx_byte <= rd_data;
                    drive_low <= ~rd_data[7];
                  end else begin
                    state <= I2C_REG;
                  end
                end
                I2C_REG: begin
                  state <= I2C_WRITE;
                end
                I2C_READ: begin
                  if (master_nack) begin
                    state <= I2C_IDLE;
                  end else begin
                    tx_byte <= rd_data;
                    drive_low <= ~rd_data[7];
                  end
                end
                default: begin
                  state <= state;
                end
              endcase
            end
            default: begin
              if (state == I2C_READ && bit_cnt != 4'h0) begin
                tx_byte <= {tx_byte[6:0], 1'b0};
                drive_low <= ~tx_byte[6];
              end
            end
          endcase
        end
      end
    end
  end

  // status capture; no software write path exists
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      thermal_flag <= 1'b0;
      valid_flags <= 6'h00;
    end else begin
      thermal_flag <= die_over_temp;
      valid_flags <= {buck_one_good & buck_two_good, linear_one_good & linear_two_good,
                      linear_two_good, linear_one_good, buck_two_good,
                      buck_one_good};
    end
  end

  // control and configuration registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      power_on_delay_select <= DELAY_SEL_DEFAULT;
      b1_pwm_bit <= B1_PWM_DEFAULT;
      b2_pwm_bit <= B2_PWM_DEFAULT;
      ext_clk_bit <= 1'b0;
      enable_bits <= ENABLE_RESET;
      {b2_sel, b2_go, b1_sel, b1_go} <= 4'h0;
      b1_tgt_a <= B1_TARGET_DEFAULT;
      b1_tgt_b <= B1_TARGET_DEFAULT;
      b2_tgt_a <= B2_TARGET_DEFAULT;
      b2_tgt_b <= B2_TARGET_DEFAULT;
      b1_rate <= RAMP_RATE_RESET;
      b2_rate <= RAMP_RATE_RESET;
      func_reg <= BYTE_RESET;
      lin1_reg <= BYTE_RESET;
      lin2_reg <= BYTE_RESET;
    end else begin
      // reserved bits are simply not stored
      if (wr_sys) begin
        power_on_delay_select <= wr_data[DELAY_SEL_LSB +: 3];
        b2_pwm_bit <= wr_data[B2_PWM_BIT];
        b1_pwm_bit <= wr_data[B1_PWM_BIT];
        ext_clk_bit <= wr_data[EXT_CLK_BIT];
      end
      if (wr_en) begin
        enable_bits <= {wr_data[EN_LIN2_BIT], wr_data[EN_LIN1_BIT], wr_data[EN_B2_BIT],
                        wr_data[EN_B1_BIT]};
      end
      if (wr_vcc) begin
        {b2_sel, b2_go} <= {wr_data[B2_SEL_BIT], wr_data[B2_GO_BIT]};
        {b1_sel, b1_go} <= {wr_data[B1_SEL_BIT], wr_data[B1_GO_BIT]};
      end
      if (wr_b1a) b1_tgt_a <= wr_data[4:0];
      if (wr_b1b) b1_tgt_b <= wr_data[4:0];
      if (wr_b1r) b1_rate <= wr_data[3:0];
      if (wr_b2a) b2_tgt_a <= wr_data[4:0];
      if (wr_b2b) b2_tgt_b <= wr_data[4:0];
      if (wr_b2r) b2_rate <= wr_data[3:0];
      if (wr_func) func_reg <= wr_data;
      if (wr_lin1) lin1_reg <= wr_data;
      if (wr_lin2) lin2_reg <= wr_data;
    end
  end

  // voltage code: held while go is low, follows the selected target while high
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      buck_one_vout_code <= B1_TARGET_DEFAULT;
      buck_two_vout_code <= B2_TARGET_DEFAULT;
    end else begin
      if (b1_go) buck_one_vout_code <= b1_sel ? b1_tgt_b : b1_tgt_a;
      if (b2_go) buck_two_vout_code <= b2_sel ? b2_tgt_b : b2_tgt_a;
    end
  end

  // start-up timer; restarts from zero whenever master enable drops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= '0;
      seq_ticks <= 5'h00;
    end else if (!master_enable) begin
      tick_cnt <= '0;
      seq_ticks <= 5'h00;
    end else if (tick_done) begin
      tick_cnt <= '0;
      // saturate so a finished sequence never wraps and shuts rails off
      if (seq_ticks != 5'h1F) seq_ticks <= seq_ticks + 5'h01;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  // registered outputs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      buck_one_on <= 1'b0;
      buck_two_on <= 1'b0;
      linear_one_on <= 1'b0;
      linear_two_on <= 1'b0;
      buck_one_force_pwm <= 1'b0;
      buck_two_force_pwm <= 1'b0;
      external_clock_select <= 1'b0;
      buck_one_ramp_rate <= RAMP_RATE_RESET;
      buck_two_ramp_rate <= RAMP_RATE_RESET;
      buck_function <= BYTE_RESET;
      linear_reg_one_voltage <= BYTE_RESET;
      linear_reg_two_voltage <= BYTE_RESET;
    end else begin
      buck_one_on <= master_enable & enable_bits[0] & b1_due;
      buck_two_on <= master_enable & enable_bits[1] & b2_due;
      linear_one_on <= master_enable & enable_bits[2] & l1_due;
      linear_two_on <= master_enable & enable_bits[3] & l2_due;
      buck_one_force_pwm <= b1_pwm_bit;
      buck_two_force_pwm <= b2_pwm_bit;
      external_clock_select <= ext_clk_bit;
      buck_one_ramp_rate <= b1_rate;
      buck_two_ramp_rate <= b2_rate;
      buck_function <= func_reg;
      linear_reg_one_voltage <= lin1_reg;
      linear_reg_two_voltage <= lin2_reg;
    end
  end

endmodule : pmic_control_register_bank
`default_nettype wire

// [test/pmic_control_register_bank_asserts.sv]
// port-level assertions for the power unit register bank
`timescale 1ns/1ps
`default_nettype none
module pmic_control_register_bank_asserts #(
  parameter int TICK_CYCLES = 10
) (
  // clock, reset and serial port
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  // sequencer
  input wire logic master_enable,
  input wire logic buck_one_on,
  input wire logic buck_two_on,
  input wire logic linear_one_on,
  input wire logic linear_two_on,
  // register copies
  input wire logic [4:0] buck_one_vout_code,
  input wire logic [7:0] buck_function,
  input wire logic [7:0] linear_reg_one_voltage
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [31:0] en_cnt;
  // cycles master_enable has been seen high; wraps only after about 21 seconds of run at 5 ns per cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      en_cnt <= 32'h0;
    end else begin
      en_cnt <= master_enable ? en_cnt + 32'h1 : 32'h0;
    end
  end
  sequence s_enable_rise;
    $rose(master_enable);
  endsequence
  sequence s_all_off;
    !buck_one_on && !buck_two_on && !linear_one_on && !linear_two_on;
  endsequence
  a_on_needs_enable: assert property ((buck_one_on || linear_two_on)
    |-> $past(master_enable))
    else $error("regulator on without master enable");
  a_enable_drop_off: assert property ($fell(master_enable) |=> s_all_off)
    else $error("regulators still on after enable drop");
  a_quiet_start: assert property (s_enable_rise |-> s_all_off [*8])
    else $error("regulator on right after enable");
  a_delay_min: assert property (($rose(buck_one_on) || $rose(linear_two_on))
    |-> en_cnt >= 2 * TICK_CYCLES)
    else $error("regulator on before shortest delay");
  a_sda_stable_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("sda drive changed while scl high");
  a_ack_low_scl: assert property ($fell(sda_oe_n) |-> !scl_in && !$past(scl_in))
    else $error("sda pulled low outside scl low");
  a_vout_write_only: assert property ($changed(buck_one_vout_code) |-> !scl_in)
    else $error("vout code moved outside a write");
  a_byte_write_only: assert property (($changed(buck_function)
    || $changed(linear_reg_one_voltage)) |-> !scl_in)
    else $error("register copy moved outside a write");
  a_on_fall_cause: assert property ($fell(buck_two_on)
    |-> !$past(master_enable) || !scl_in)
    else $error("buck two off without cause");
endmodule : pmic_control_register_bank_asserts
bind pmic_control_register_bank pmic_control_register_bank_asserts #(
  .TICK_CYCLES(TICK_CYCLES)) u_asserts (.mclk(mclk), .reset_n(reset_n), .scl_in(scl_in),
  .sda_oe_n(sda_oe_n), .master_enable(master_enable), .buck_one_on(buck_one_on),
  .buck_two_on(buck_two_on), .linear_one_on(linear_one_on), .linear_two_on(linear_two_on),
  .buck_one_vout_code(buck_one_vout_code), .buck_function(buck_function),
  .linear_reg_one_voltage(linear_reg_one_voltage));
`default_nettype wire

// [test/i2c_host_model.sv]
// serial host model: start, stop, bytes and register cycles
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  // clock and bus
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : q
  // works as first or repeated start: sda released while scl low
  task automatic start_c();
    sda_pull = 1'b0;
    q(4);
    scl = 1'b1;
    q(4);
    sda_pull = 1'b1;
    q(4);
    scl = 1'b0;
    q(4);
  endtask : start_c
  task automatic stop_c();
    sda_pull = 1'b1;
    q(4);
    scl = 1'b1;
    q(4);
    sda_pull = 1'b0;
    q(4);
  endtask : stop_c
  // hold after scl fall so data never moves with the clock edge
  task automatic bit_c(input logic b, output logic r);
    sda_pull = ~b;
    q(4);
    scl = 1'b1;
    q(4);
    r = sda;
    scl = 1'b0;
    q(2);
  endtask : bit_c
  task automatic byte_c(input logic [7:0] d, input logic nine, output logic [7:0] r,
    output logic n);
    for (int i = 7; i >= 0; i--) bit_c(d[i], r[i]);
    bit_c(nine, n);
  endtask : byte_c
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
    output logic ok);
    logic [7:0] r;
    logic n0, n1, n2;
    start_c();
    byte_c({dev, 1'b0}, 1'b1, r, n0);
    byte_c(a, 1'b1, r, n1);
    byte_c(d, 1'b1, r, n2);
    stop_c();
    ok = ~(n0 | n1 | n2);
  endtask : write_reg
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d,
    output logic ok);
    logic [7:0] r;
    logic n0, n1, n2, n3;
    start_c();
    byte_c({dev, 1'b0}, 1'b1, r, n0);
    byte_c(a, 1'b1, r, n1);
    start_c();
    byte_c({dev, 1'b1}, 1'b1, r, n2);
    byte_c(8'hFF, 1'b1, d, n3);
    stop_c();
    ok = ~(n0 | n1 | n2);
  endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

// [test/tb_pmic_control_register_bank.sv]
// self-checking bench for the power unit register bank
`timescale 1ns/1ps
`default_nettype none
module tb_pmic_control_register_bank;
  import pmic_regs_pkg::*;
  localparam int TCK = 10;
  localparam logic [6:0] DEV = 7'h2A; // arbitrary value
  localparam logic [7:0] MAP [0:16] = '{8'h02, 8'h07, 8'h10, 8'h11, 8'h20, 8'h23, 8'h24,
    8'h25, 8'h29, 8'h2A, 8'h2B, 8'h38, 8'h39, 8'h3A, 8'h05, 8'h12, 8'hFF};
  localparam logic [7:0] VCS [0:5] = '{8'h11, 8'h22, 8'h00, 8'h33, 8'h10, 8'h01};
  // half-ms ticks per code: buck one, buck two, linear one, linear two
  localparam int DLY [0:31] = '{2, 2, 2, 2, 2, 3, 4, 4, 3, 4, 6, 12, 3, 4, 2, 2,
    3, 4, 6, 12, 3, 3, 4, 4, 6, 4, 2, 3, 4, 6, 12, 22};
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic hot = 1'b0;
  logic men = 1'b0;
  logic [3:0] good = 4'h0;
  logic scl, pull, sda, sda_out, sda_oe_n, pwm1, pwm2, eclk;
  logic [3:0] on, rr1, rr2;
  logic [4:0] v1, v2;
  logic [7:0] bf, lv1, lv2;
  logic [7:0] shadow [0:255];
  int error_cnt = 0;
  int checks = 0;
  always #2.5 mclk = ~mclk;
  assign sda = ~(pull | (~sda_oe_n & ~sda_out));
  i2c_host_model host (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(pull));
  pmic_control_register_bank #(.SLAVE_ADDR(DEV), .TICK_CYCLES(TCK)) dut (
    .mclk(mclk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .die_over_temp(hot), .master_enable(men),
    .buck_one_good(good[0]), .buck_two_good(good[1]), .linear_one_good(good[2]),
    .linear_two_good(good[3]), .buck_one_on(on[0]), .buck_two_on(on[1]),
    .linear_one_on(on[2]), .linear_two_on(on[3]), .buck_one_force_pwm(pwm1),
    .buck_two_force_pwm(pwm2), .external_clock_select(eclk), .buck_one_vout_code(v1),
    .buck_two_vout_code(v2), .buck_one_ramp_rate(rr1), .buck_two_ramp_rate(rr2),
    .buck_function(bf), .linear_reg_one_voltage(lv1), .linear_reg_two_voltage(lv2));
  function automatic logic [7:0] wmask(input logic [7:0] a, input logic [7:0] v);
    case (a)
      ADDR_SYS_CTRL: return (v & 8'h77) | 8'h08;
      ADDR_REG_ENABLE: return (v & 8'h55) | 8'h20;
      ADDR_VOLT_CHANGE: return v & 8'h33;
      ADDR_B1_RAMP, ADDR_B2_RAMP: return (v & 8'h0F) | 8'h20;
      ADDR_B1_TGT_A, ADDR_B1_TGT_B, ADDR_B2_TGT_A, ADDR_B2_TGT_B: return v & 8'h1F;
      ADDR_BUCK_FUNC, ADDR_LIN1_VOLT, ADDR_LIN2_VOLT: return v;
      default: return shadow[a];
    endcase
  endfunction : wmask
  // status bits follow the monitor inputs, not the shadow
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      ADDR_INT_STATUS: return {6'h00, hot, 1'b0};
      ADDR_OUT_STATUS: return {&good[1:0], &good[3:2], good[3], good[2], 1'b0, good[1],
        1'b0, good[0]};
      default: return shadow[a];
    endcase
  endfunction : exp_rd
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.write_reg(DEV, a, d, ok);
    chk8("ack", 8'h01, {7'h00, ok});
    shadow[a] = wmask(a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ok;
    logic [7:0] d;
    host.read_reg(DEV, a, d, ok);
    chk8("ack", 8'h01, {7'h00, ok});
    chk8($sformatf("reg %h", a), exp_rd(a), d);
  endtask : rd
  task automatic reset_check();
    shadow = '{default: 8'h00};
    shadow[8'h07] = 8'h28;
    shadow[8'h10] = 8'h75;
    shadow[8'h25] = 8'h28;
    shadow[8'h2B] = 8'h28;
    for (int i = 0; i < 17; i++) rd(MAP[i]);
    chk8("pwm", 8'h00, {6'h00, pwm2, pwm1});
    chk8("ramp", 8'h88, {rr2, rr1});
    $display("test reset values done");
  endtask : reset_check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    int seed;
    int f [4];
    logic ok;
    logic [4:0] e1, e2;
    logic [7:0] vc;
    seed = $urandom(32'h4d743443);
    tick(8);
    reset_n = 1'b1;
    tick(4);
    reset_check();
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 17; i++) begin
        hot = (k == 0) ? 1'b1 : 1'($urandom);
        good = (k == 0) ? 4'hF : 4'($urandom);
        wr(MAP[i], (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom));
        rd(MAP[i]);
      end
    end
    chk8("mode", {5'h00, shadow[8'h07][2:0]}, {5'h00, pwm2, pwm1, eclk});
    chk8("ramp1", {4'h0, shadow[8'h25][3:0]}, {4'h0, rr1});
    chk8("ramp2", {4'h0, shadow[8'h2B][3:0]}, {4'h0, rr2});
    chk8("func", shadow[8'h38], bf);
    chk8("lin1", shadow[8'h39], lv1);
    chk8("lin2", shadow[8'h3A], lv2);
    $display("test register access done");
    wr(ADDR_B1_TGT_A, 8'h05);
    wr(ADDR_B1_TGT_B, 8'h0A);
    wr(ADDR_B2_TGT_A, 8'h11);
    wr(ADDR_B2_TGT_B, 8'h16);
    for (int i = 0; i < 6; i++) begin
      vc = VCS[i];
      wr(ADDR_VOLT_CHANGE, vc);
      if (vc[0]) e1 = vc[1] ? 5'h0A : 5'h05;
      if (vc[4]) e2 = vc[5] ? 5'h16 : 5'h11;
      chk8("vout1", {3'h0, e1}, {3'h0, v1});
      chk8("vout2", {3'h0, e2}, {3'h0, v2});
    end
    $display("test voltage change done");
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_REG_ENABLE, 8'h55);
      wr(ADDR_SYS_CTRL, {1'b0, 3'(c), 4'h0});
      f = '{0, 0, 0, 0};
      men = 1'b1;
      for (int n = 1; n < 300; n++) begin
        tick(1);
        for (int j = 0; j < 4; j++) if (on[j] === 1'b1 && f[j] == 0) f[j] = n;
      end
      for (int j = 0; j < 4; j++) begin
        chk_rng("on delay", DLY[c*4+j]*TCK, DLY[c*4+j]*TCK+4, f[j]);
      end
      if (c == 7) begin
        wr(ADDR_REG_ENABLE, 8'h14);
        chk8("on", 8'h06, {4'h0, on});
      end
      men = 1'b0;
      tick(2);
      chk8("on", 8'h00, {4'h0, on});
    end
    $display("test start-up sequence done");
    reset_n = 1'b0;
    tick(3);
    reset_n = 1'b1;
    tick(4);
    reset_check();
    host.write_reg(7'h15, ADDR_LIN1_VOLT, 8'hA5, ok);
    chk8("nack", 8'h00, {7'h00, ok});
    rd(ADDR_LIN1_VOLT);
    $display("test foreign address done");
    report_and_stop();
  end
  // whole run is near 60k cycles; half again more is a hang
  initial begin
    #450000;
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_pmic_control_register_bank
`default_nettype wire
